// >>> include/tmr_pkg.sv
`default_nettype none
package tmr_pkg;
  // Register offsets (byte addresses on the register bus).
  localparam logic [7:0] ADDR_CONTROL_A = 8'h30;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h33;
  localparam logic [7:0] ADDR_COUNT = 8'h34;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h38;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h3c;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h40;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h44;
  localparam logic [7:0] ADDR_IRQ_ACK = 8'h48;
  // Control B fields.
  localparam int FOC_A_BIT = 7;
  localparam int FOC_B_BIT = 6;
  localparam int WGM2_BIT = 3;
  localparam int CS_HI = 2;
  // Control A fields (own register).
  localparam int COMA_HI = 7;
  localparam int COMA_LO = 6;
  localparam int COMB_HI = 5;
  localparam int COMB_LO = 4;
  localparam int WGM_HI = 1;
  // Flag / enable positions.
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_OVF = 0;
  localparam logic [2:0] FLAG_MASK = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  // Prescaler taps.
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tmr_clk_sel_e;
  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000,
    WM_PC_PWM = 3'b001,
    WM_CTC = 3'b010,
    WM_FAST_PWM = 3'b011,
    WM_RSVD4 = 3'b100,
    WM_PC_PWM_TOPA = 3'b101,
    WM_RSVD6 = 3'b110,
    WM_FAST_PWM_TOPA = 3'b111
  } tmr_wave_mode_e;
  typedef enum logic [1:0] {
    COM_OFF = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } tmr_com_e;
endpackage
`default_nettype wire

// >>> rtl/tmr_timer8.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Force A strobes channel A output in non-PWM.
// - Force B strobes channel B output in non-PWM.
// - Forced strobe sets no flag, clears nothing.
// - Force bits read zero, ignored in PWM.
// - Control B bits 5:4 read zero.
// - Clock select stop, div 1/8/64/256/1024.
// - Codes 6 and 7 count pin edges.
// - Pin edges count even when output.
// - Counter register readable and writable.
// - Counter write blocks next tick match.
// - Compare registers match count continuously.
// - Enables at bits 2,1,0 gate requests.
// - Mask and flag bits 7:3 read zero.
// - Compare B match sets flag bit 2.
// - Compare A match sets flag bit 1.
// - Vector acknowledge clears flag by hardware.
// - Writing one clears flag; zero keeps.
// - Overflow flag point depends on mode.
// - Mode field selects normal, CLEAR_ON_MATCH_MODE, PWMs.
// - Non-PWM output modes toggle, clear, set.
module tmr_timer8 (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  // Processor interrupt side
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic [2:0] VECTOR_ACK_I,
  output logic [2:0] IRQ_REQ_O,
  // Pins
  input wire logic EXTERNAL_COUNT_PIN_I,
  output logic WAVE_OUT_A_O,
  output logic WAVE_OUT_A_EN_O,
  output logic WAVE_OUT_B_O,
  output logic WAVE_OUT_B_EN_O
);
  logic [7:0] ctrl_a;
  logic [3:0] ctrl_b;
  logic [7:0] count;
  logic [7:0] cmp_a, cmp_b;
  logic [2:0] irq_en;
  logic [2:0] flags;
  logic [9:0] presc;
  logic [2:0] pin_sync;
  logic pin_last;
  logic tick, down;
  logic block_match;
  logic wave_a, wave_b;
  logic req, wr, rd_ok;
  logic [7:0] rd_byte;
  logic [7:0] top;
  logic pwm_mode, fast_mode, pc_mode;
  logic match_a, match_b;
  logic force_a, force_b;
  logic wr_count;
  logic [7:0] next_count;
  logic next_down;
  logic ovf_evt;
  logic pin_rise, pin_fall;
  tmr_pkg::tmr_wave_mode_e mode;
  tmr_pkg::tmr_clk_sel_e clk_sel;

  function automatic logic valid_adr(input logic [7:0] a);
    valid_adr = (a == tmr_pkg::ADDR_CONTROL_A) ||
                (a == tmr_pkg::ADDR_CONTROL_B) ||
                (a == tmr_pkg::ADDR_COUNT) ||
                (a == tmr_pkg::ADDR_COMPARE_A) ||
                (a == tmr_pkg::ADDR_COMPARE_B) ||
                (a == tmr_pkg::ADDR_IRQ_ENABLES) ||
                (a == tmr_pkg::ADDR_IRQ_FLAGS);
  endfunction

  // Output-mode action on a match; next pin level.
  function automatic logic com_apply(input logic [1:0] com,
                                     input logic cur);
    unique case (com)
      tmr_pkg::COM_TOGGLE: com_apply = ~cur;
      tmr_pkg::COM_CLEAR: com_apply = 1'b0;
      tmr_pkg::COM_SET: com_apply = 1'b1;
      default: com_apply = cur;
    endcase
  endfunction

  // Bus decode: the ack comes one cycle after the request.
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  assign rd_ok = valid_adr(WB_ADR_I);
  assign wr = req && WB_WE_I && rd_ok && WB_SEL_I[0];

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && rd_ok;
      WB_ERR_O <= req && !rd_ok;
    end
  end

  always_comb begin
    rd_byte = tmr_pkg::RESET_BYTE;
    unique case (WB_ADR_I)
      tmr_pkg::ADDR_CONTROL_A: rd_byte = ctrl_a;
      // force strobes and reserved bits read zero.
      tmr_pkg::ADDR_CONTROL_B: rd_byte = {4'h0, ctrl_b};
      tmr_pkg::ADDR_COUNT: rd_byte = count;
      tmr_pkg::ADDR_COMPARE_A: rd_byte = cmp_a;
      tmr_pkg::ADDR_COMPARE_B: rd_byte = cmp_b;
      // upper mask and flag bits read zero.
      tmr_pkg::ADDR_IRQ_ENABLES: rd_byte = {5'h00, irq_en};
      tmr_pkg::ADDR_IRQ_FLAGS: rd_byte = {5'h00, flags};
      default: rd_byte = tmr_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      WB_DAT_O <= {24'h00_0000, rd_byte};
    end
  end

  // Configuration registers.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_a <= tmr_pkg::RESET_BYTE;
      ctrl_b <= 4'h0;
      cmp_a <= tmr_pkg::RESET_BYTE;
      cmp_b <= tmr_pkg::RESET_BYTE;
      irq_en <= 3'h0;
    end else if (wr) begin
      unique case (WB_ADR_I)
        tmr_pkg::ADDR_CONTROL_A: ctrl_a <= WB_DAT_I[7:0];
        tmr_pkg::ADDR_CONTROL_B: ctrl_b <= WB_DAT_I[3:0];
        tmr_pkg::ADDR_COMPARE_A: cmp_a <= WB_DAT_I[7:0];
        tmr_pkg::ADDR_COMPARE_B: cmp_b <= WB_DAT_I[7:0];
        tmr_pkg::ADDR_IRQ_ENABLES: irq_en <= WB_DAT_I[2:0];
        default: ;
      endcase
    end
  end

  assign mode = tmr_pkg::tmr_wave_mode_e'({ctrl_b[tmr_pkg::WGM2_BIT],
                                           ctrl_a[tmr_pkg::WGM_HI:0]});
  assign clk_sel = tmr_pkg::tmr_clk_sel_e'(ctrl_b[tmr_pkg::CS_HI:0]);
  assign fast_mode = (mode == tmr_pkg::WM_FAST_PWM) ||
                     (mode == tmr_pkg::WM_FAST_PWM_TOPA);
  assign pc_mode = (mode == tmr_pkg::WM_PC_PWM) ||
                   (mode == tmr_pkg::WM_PC_PWM_TOPA);
  assign pwm_mode = fast_mode || pc_mode;
  assign top = (mode == tmr_pkg::WM_CTC || mode == tmr_pkg::WM_PC_PWM_TOPA ||
                mode == tmr_pkg::WM_FAST_PWM_TOPA) ? cmp_a
                                                   : tmr_pkg::COUNT_MAX;

  // strobes act only in non-PWM modes.
  assign force_a = wr && WB_ADR_I == tmr_pkg::ADDR_CONTROL_B &&
                   WB_DAT_I[tmr_pkg::FOC_A_BIT] && !pwm_mode;
  assign force_b = wr && WB_ADR_I == tmr_pkg::ADDR_CONTROL_B &&
                   WB_DAT_I[tmr_pkg::FOC_B_BIT] && !pwm_mode;
  assign wr_count = wr && WB_ADR_I == tmr_pkg::ADDR_COUNT;

  // Prescaler runs free from reset.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      presc <= 10'h000;
    end else begin
      presc <= presc + 10'h001;
    end
  end

  // the pin is sampled regardless of its direction.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_sync <= 3'h0;
      pin_last <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], EXTERNAL_COUNT_PIN_I};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_last <= pin_sync[2];
      end
    end
  end
  assign pin_rise = (pin_sync[1] == pin_sync[2]) && pin_sync[2] && !pin_last;
  assign pin_fall = (pin_sync[1] == pin_sync[2]) && !pin_sync[2] && pin_last;

  always_comb begin
    unique case (clk_sel)
      tmr_pkg::CS_STOP: tick = 1'b0;
      tmr_pkg::CS_DIV1: tick = 1'b1;
      tmr_pkg::CS_DIV8: tick = (presc & tmr_pkg::DIV8_MASK) == 10'h000;
      tmr_pkg::CS_DIV64: tick = (presc & tmr_pkg::DIV64_MASK) == 10'h000;
      tmr_pkg::CS_DIV256: tick = (presc & tmr_pkg::DIV256_MASK) == 10'h000;
      tmr_pkg::CS_DIV1024: tick = (presc & tmr_pkg::DIV1024_MASK) == 10'h000;
      tmr_pkg::CS_EXT_FALL: tick = pin_fall;
      tmr_pkg::CS_EXT_RISE: tick = pin_rise;
    endcase
  end

  // continuous compare, masked after a counter write.
  // match blocked on the first tick after a write.
  assign match_a = tick && count == cmp_a && !block_match;
  assign match_b = tick && count == cmp_b && !block_match;

  // Counting sequence per mode.
  always_comb begin
    next_count = count;
    next_down = down;
    ovf_evt = 1'b0;
    if (pc_mode) begin
      if (!down && count == top) begin
        next_down = 1'b1;
        next_count = count - 8'h01;
      end else if (down && count == tmr_pkg::COUNT_BOTTOM) begin
        next_down = 1'b0;
        next_count = count + 8'h01;
        ovf_evt = 1'b1;
      end else begin
        next_count = down ? count - 8'h01 : count + 8'h01;
      end
    end else if (count == top) begin
      next_count = tmr_pkg::COUNT_BOTTOM;
      next_down = 1'b0;
      // overflow at max, or at top in fast PWM with A as top.
      ovf_evt = (mode == tmr_pkg::WM_FAST_PWM_TOPA) ||
                (count == tmr_pkg::COUNT_MAX);
    end else begin
      next_count = count + 8'h01;
      next_down = 1'b0;
      ovf_evt = (count == tmr_pkg::COUNT_MAX);
    end
  end

  // direct counter access; force never clears it.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      count <= tmr_pkg::COUNT_BOTTOM;
      down <= 1'b0;
    end else if (wr_count) begin
      count <= WB_DAT_I[7:0];
    end else if (tick) begin
      count <= next_count;
      down <= next_down;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // forced strobes are not set sources.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == tmr_pkg::FLAG_CMPB && match_b) ||
            (i == tmr_pkg::FLAG_CMPA && match_a) ||
            (i == tmr_pkg::FLAG_OVF && tick && ovf_evt && !wr_count)) begin
          flags[i] <= 1'b1;
        end else if (VECTOR_ACK_I[i] ||
                     (wr && WB_ADR_I == tmr_pkg::ADDR_IRQ_FLAGS &&
                      WB_DAT_I[i])) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  assign IRQ_REQ_O = flags & irq_en & {3{GLOBAL_IRQ_EN_I}} &
                     tmr_pkg::FLAG_MASK;

  // waveform outputs; force uses the same action.
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wave_a <= 1'b0;
    end else if (!pwm_mode && (match_a || force_a)) begin
      wave_a <= com_apply(ctrl_a[tmr_pkg::COMA_HI:tmr_pkg::COMA_LO], wave_a);
    end else if (fast_mode && tick) begin
      if (count == top) begin
        wave_a <= ctrl_a[tmr_pkg::COMA_LO] ? 1'b0 : 1'b1;
      end else if (count == cmp_a) begin
        wave_a <= ctrl_a[tmr_pkg::COMA_LO];
      end
    end else if (pc_mode && tick && count == cmp_a) begin
      wave_a <= ctrl_a[tmr_pkg::COMA_LO] ^ down;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wave_b <= 1'b0;
    end else if (!pwm_mode && (match_b || force_b)) begin
      wave_b <= com_apply(ctrl_a[tmr_pkg::COMB_HI:tmr_pkg::COMB_LO], wave_b);
    end else if (fast_mode && tick) begin
      if (count == top) begin
        wave_b <= ctrl_a[tmr_pkg::COMB_LO] ? 1'b0 : 1'b1;
      end else if (count == cmp_b) begin
        wave_b <= ctrl_a[tmr_pkg::COMB_LO];
      end
    end else if (pc_mode && tick && count == cmp_b) begin
      wave_b <= ctrl_a[tmr_pkg::COMB_LO] ^ down;
    end
  end

  assign WAVE_OUT_A_O = wave_a;
  assign WAVE_OUT_B_O = wave_b;
  assign WAVE_OUT_A_EN_O = ctrl_a[tmr_pkg::COMA_HI:tmr_pkg::COMA_LO] != 2'b00;
  assign WAVE_OUT_B_EN_O = ctrl_a[tmr_pkg::COMB_HI:tmr_pkg::COMB_LO] != 2'b00;

  AST_FORCE_A: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    force_a && !match_a && ctrl_a[7:6] == 2'b01 |=> wave_a != $past(wave_a))
    else $error("forced toggle A missing");
  AST_FORCE_B: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    force_b && !match_b && ctrl_a[5:4] == 2'b11 |=> wave_b)
    else $error("forced set B missing");
  AST_FORCE_NOFLAG: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I)
    force_a && !match_a && !flags[1] && !VECTOR_ACK_I[1] |=> !flags[1])
    else $error("force set a flag");
  AST_CTRLB_RD: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    WB_ACK_O && $past(WB_ADR_I) == tmr_pkg::ADDR_CONTROL_B && !$past(WB_WE_I)
    |-> WB_DAT_O[7:4] == 4'h0)
    else $error("control B high bits nonzero");
  AST_STOPPED: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    clk_sel == tmr_pkg::CS_STOP && !wr_count |=> count == $past(count))
    else $error("counter moved while stopped");
  AST_BLOCK: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    wr_count ##1 (tick && !wr_count) |-> !match_a && !match_b)
    else $error("match after counter write");
  AST_CMPA_SET: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    match_a |=> flags[1])
    else $error("compare A flag not set");
  AST_W1C: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    wr && WB_ADR_I == tmr_pkg::ADDR_IRQ_FLAGS && WB_DAT_I[2] && !match_b
    |=> !flags[2])
    else $error("write one did not clear B");
  AST_IRQ: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    IRQ_REQ_O[0] |-> flags[0] && irq_en[0] && GLOBAL_IRQ_EN_I)
    else $error("overflow request without cause");
endmodule // tmr_timer8
`default_nettype wire

// >>> verif/tmr_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmr_cpu_model (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  // Interrupt side
  output logic gie_o,
  output logic [2:0] vack_o
);
  logic [2:0] wm = 3'h0;
  time t_ack;
  initial begin
    {cyc_o, stb_o, we_o, gie_o} = 4'h0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
    vack_o = 3'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] wd, output logic [7:0] rd, output logic e,
    output logic ok);
    logic [7:0] d;
    int n;
    d = wd;
    if (w && a == tmr_pkg::ADDR_CONTROL_A) wm[1:0] = wd[1:0];
    if (w && a == tmr_pkg::ADDR_CONTROL_B) wm[2] = wd[3];
    if (w && a == tmr_pkg::ADDR_CONTROL_B && wm[0]) d = wd & 8'h3f;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && err_i !== 1'b1 && n < 64);
    rd = dat_i[7:0];
    e = err_i;
    ok = (n < 64);
    t_ack = $time;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
  endtask
  task automatic set_gie(input logic v);
    @(posedge clk_i);
    gie_o <= v;
  endtask
  task automatic vector(input int i);
    @(posedge clk_i);
    vack_o <= 3'h1 << i;
    @(posedge clk_i);
    vack_o <= 3'h0;
  endtask
endmodule // tmr_cpu_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst_n, cyc, stb, we, ack, err, gie, pin;
  logic wa, wae, wb, wbe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [2:0] vack, irq;
  logic [7:0] c, x;
  int failures = 0;
  int tests_run = 0;
  tmr_timer8 uut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .WB_ERR_O(err),
    .GLOBAL_IRQ_EN_I(gie), .VECTOR_ACK_I(vack), .IRQ_REQ_O(irq),
    .EXTERNAL_COUNT_PIN_I(pin), .WAVE_OUT_A_O(wa),
    .WAVE_OUT_A_EN_O(wae), .WAVE_OUT_B_O(wb), .WAVE_OUT_B_EN_O(wbe));
  tmr_cpu_model cpu (.clk_i(clk), .ack_i(ack), .err_i(err),
    .dat_i(dr), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(dw), .gie_o(gie), .vack_o(vack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] r, output logic e);
    logic ok;
    cpu.xfer(w, a, d, r, e, ok);
    if (!ok) begin
      failures++;
      $display("FAIL t=%0t bus wait got=%h exp=%h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    logic e;
    bus(1'b0, a, 8'h00, r, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd(a, r);
    chk(r, e);
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [7:0] r;
    logic e;
    rdchk(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'hff);
    rdchk(tmr_pkg::ADDR_CONTROL_B, 8'h0f);
    wr(tmr_pkg::ADDR_IRQ_ENABLES, 8'hff);
    rdchk(tmr_pkg::ADDR_IRQ_ENABLES, 8'h07);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'hff);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    bus(1'b0, 8'h50, 8'h00, r, e);
    chk({7'h0, e}, 8'h01);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    wr(tmr_pkg::ADDR_IRQ_ENABLES, 8'h00);
    wr(tmr_pkg::ADDR_COUNT, 8'h5a);
    rdchk(tmr_pkg::ADDR_COUNT, 8'h5a);
    $display("test regs done");
  endtask
  task automatic t_clock;
    int dv[5] = '{1, 8, 64, 256, 1024};
    logic [7:0] a, b;
    time t1;
    int iv, e;
    for (int i = 1; i <= 5; i++) begin
      wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
      wr(tmr_pkg::ADDR_COUNT, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL_B, 8'(i));
      rd(tmr_pkg::ADDR_COUNT, a);
      t1 = cpu.t_ack;
      cyc_n(dv[i-1] * 3);
      rd(tmr_pkg::ADDR_COUNT, b);
      iv = int'((cpu.t_ack - t1) / 10);
      e = iv / dv[i-1];
      if (i > 1 && 8'(b - a) == 8'(e + 1)) e = e + 1;
      chk(8'(b - a), 8'(e));
    end
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rd(tmr_pkg::ADDR_COUNT, a);
    cyc_n(20);
    rdchk(tmr_pkg::ADDR_COUNT, a);
    for (int m = 0; m < 2; m++) begin
      wr(tmr_pkg::ADDR_CONTROL_B, m ? 8'h07 : 8'h06);
      rd(tmr_pkg::ADDR_COUNT, a);
      repeat (3) begin
        pin <= 1'b1;
        cyc_n(5);
        pin <= 1'b0;
        cyc_n(5);
      end
      cyc_n(8);
      rdchk(tmr_pkg::ADDR_COUNT, 8'(a + 3));
    end
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    $display("test clock done");
  endtask
  task automatic t_flags;
    wr(tmr_pkg::ADDR_COMPARE_A, 8'h10);
    wr(tmr_pkg::ADDR_COMPARE_B, 8'h20);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h07);
    wr(tmr_pkg::ADDR_COUNT, 8'h00);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    cyc_n(60);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h06);
    cpu.set_gie(1'b1);
    cyc_n(1);
    chk({5'h0, irq}, 8'h00);
    wr(tmr_pkg::ADDR_IRQ_ENABLES, 8'h07);
    chk({5'h0, irq}, 8'h06);
    cpu.set_gie(1'b0);
    cyc_n(1);
    chk({5'h0, irq}, 8'h00);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h01);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h06);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h02);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h04);
    cpu.vector(2);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(tmr_pkg::ADDR_COUNT, 8'hfe);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    cyc_n(8);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h01);
    cpu.set_gie(1'b1);
    cyc_n(1);
    chk({5'h0, irq}, 8'h01);
    cpu.vector(0);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(tmr_pkg::ADDR_COMPARE_A, 8'h05);
    wr(tmr_pkg::ADDR_COUNT, 8'h30);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h07);
    wr(tmr_pkg::ADDR_COUNT, 8'h05);
    cyc_n(16);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_wave;
    wr(tmr_pkg::ADDR_COMPARE_A, 8'h10);
    wr(tmr_pkg::ADDR_CONTROL_A, 8'h02);
    wr(tmr_pkg::ADDR_COUNT, 8'h00);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    cyc_n(100);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rd(tmr_pkg::ADDR_COUNT, c);
    chk({7'h0, c <= 8'h10}, 8'h01);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h07);
    wr(tmr_pkg::ADDR_CONTROL_A, 8'h70);
    cyc_n(2);
    chk({6'h0, wae, wbe}, 8'h03);
    x = {7'h0, ~wa};
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h80);
    cyc_n(2);
    chk({7'h0, wa}, x);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h40);
    cyc_n(2);
    chk({7'h0, wb}, 8'h01);
    wr(tmr_pkg::ADDR_CONTROL_A, 8'ha2);
    wr(tmr_pkg::ADDR_COUNT, 8'h33);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'hc0);
    cyc_n(2);
    chk({6'h0, wa, wb}, 8'h00);
    rdchk(tmr_pkg::ADDR_COUNT, 8'h33);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    // Phase-correct mode: nothing at max, overflow only at bottom.
    wr(tmr_pkg::ADDR_CONTROL_A, 8'h01);
    wr(tmr_pkg::ADDR_IRQ_FLAGS, 8'h07);
    wr(tmr_pkg::ADDR_COUNT, 8'hfd);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    cyc_n(100);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h01);
    cyc_n(170);
    wr(tmr_pkg::ADDR_CONTROL_B, 8'h00);
    rdchk(tmr_pkg::ADDR_IRQ_FLAGS, 8'h07);
    $display("test wave done");
  endtask
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_clock();
    t_flags();
    t_wave();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
